// *** rtl/rah_pkg.sv ***
// Purpose: Constants for the access hold and timeout logic of the clock block
// Assumes: 25 MHz system clock, 32.768 kHz oscillator level sampled on it
// Notes: Timeout counted in oscillator ticks
package rah_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int OSC_HZ = 32_768;
  localparam int TIMEOUT_MIN_MS = 500;
  localparam int TIMEOUT_MAX_MS = 1000;
  localparam int TIMEOUT_SET_MS = 750;
  localparam int TIMEOUT_TICKS_DEF = TIMEOUT_SET_MS * OSC_HZ / 1000;
  localparam int TIMEOUT_MAX_TICKS = TIMEOUT_MAX_MS * OSC_HZ / 1000;
  localparam int CARRY_WIN_NS = 61_000;
  localparam int CARRY_WIN_CYC = CARRY_WIN_NS / (1_000_000_000 / CLK_HZ);
  localparam int TO_W = 16;
  localparam logic [TO_W-1:0] TO_ZERO = 16'h0000;
  localparam logic [TO_W-1:0] TO_ONE = 16'h0001;
  localparam logic [3:0] PTR_AFTER_STOP = 4'hf;
  localparam logic [3:0] PTR_ONE = 4'h1;
  localparam logic [7:0] READ_ABORT = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    RAH_IDLE = 2'b00,
    RAH_ACTIVE = 2'b01,
    RAH_ABORTED = 2'b11
  } rah_state_t;
endpackage : rah_pkg

// *** rtl/rah_top.sv ***
// Purpose: Freeze, deferred carry, access timeout and pointer for the serial port
// Assumes: Start, stop and byte events are one-cycle pulses from the bus front end
// Notes: All inputs synchronous to clock; ce low freezes every flop
module rah_top #(
  parameter int TIMEOUT_TICKS = rah_pkg::TIMEOUT_TICKS_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic osc_level,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic ptr_load,
  input wire logic [3:0] ptr_load_val,
  input wire logic byte_done,
  input wire logic carry_due,
  input wire logic [7:0] reg_rd_data,
  output logic time_freeze,
  output logic carry_apply,
  output logic [3:0] addr_ptr,
  output logic ack_enable,
  output logic [7:0] tx_byte,
  output logic fixed_freq_clock_out,
  output logic access_aborted
);
  import rah_pkg::*;

  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_TICKS - 1);

  rah_state_t state;
  rah_state_t next_state;
  logic osc_q;
  logic [TO_W-1:0] to_cnt;
  logic [TO_W-1:0] next_to_cnt;
  logic carry_pend;
  logic [3:0] next_ptr;

  // Decode
  wire osc_tick = osc_level & ~osc_q;
  wire is_idle = (state == RAH_IDLE);
  wire is_active = (state == RAH_ACTIVE);
  wire is_aborted = (state == RAH_ABORTED);
  wire start_first = start_det & is_idle;
  wire timeout_hit = is_active & osc_tick & (to_cnt == TO_LAST);
  wire next_freeze = (next_state == RAH_ACTIVE);
  wire next_abort = (next_state == RAH_ABORTED);
  wire carry_any = carry_due | carry_pend;
  wire next_carry_pend = carry_any & next_freeze;
  wire next_carry_apply = carry_any & ~next_freeze;
  wire ptr_inc = byte_done & ~is_aborted;
  wire ptr_set = ptr_load & ~is_aborted;

  // State selection
  always_comb begin
    next_state = state;
    case (state)
      RAH_IDLE: begin
        if (start_det) begin
          next_state = RAH_ACTIVE;
        end
      end
      RAH_ACTIVE: begin
        if (stop_det) begin
          next_state = RAH_IDLE;
        end else if (timeout_hit) begin
          next_state = RAH_ABORTED;
        end
      end
      RAH_ABORTED: begin
        if (stop_det) begin
          next_state = RAH_IDLE;
        end
      end
      default: begin
        next_state = RAH_IDLE;
      end
    endcase
  end

  // Timeout counter on oscillator ticks
  assign next_to_cnt = start_first ? TO_ZERO :
                       (is_active & osc_tick) ? to_cnt + TO_ONE : to_cnt;

  assign next_ptr = (stop_det | timeout_hit) ? PTR_AFTER_STOP :
                    ptr_set ? ptr_load_val :
                    ptr_inc ? addr_ptr + PTR_ONE : addr_ptr;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= RAH_IDLE;
      osc_q <= 1'b0;
      to_cnt <= TO_ZERO;
      carry_pend <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      osc_q <= osc_level;
      to_cnt <= next_to_cnt;
      carry_pend <= next_carry_pend;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      time_freeze <= 1'b0;
      carry_apply <= 1'b0;
      addr_ptr <= PTR_AFTER_STOP;
      ack_enable <= 1'b1;
      tx_byte <= BYTE_ZERO;
      fixed_freq_clock_out <= 1'b0;
      access_aborted <= 1'b0;
    end else if (ce) begin
      time_freeze <= next_freeze;
      carry_apply <= next_carry_apply;
      addr_ptr <= next_ptr;
      ack_enable <= ~next_abort;
      tx_byte <= next_abort ? READ_ABORT : reg_rd_data;
      fixed_freq_clock_out <= osc_level;
      access_aborted <= next_abort;
    end
  end

  // Checks
  AST_FREEZE_START: assert property (@(posedge clock) disable iff (!rst_n)
    ce && is_idle && start_det |=> time_freeze && is_active)
    else $error("Freeze not taken at start");

  AST_FREEZE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    is_active && !stop_det && !timeout_hit ##1 is_active |-> time_freeze && !carry_apply)
    else $error("Freeze or carry wrong during access");

  AST_CARRY_AFTER_STOP: assert property (@(posedge clock) disable iff (!rst_n)
    ce && carry_pend && is_active && stop_det |=> carry_apply && !carry_pend)
    else $error("Deferred carry not applied after stop");

  AST_CARRY_KEPT: assert property (@(posedge clock) disable iff (!rst_n)
    ce && carry_due && is_active && !stop_det && !timeout_hit |=> carry_pend && !carry_apply)
    else $error("Carry lost during freeze");

  AST_TIMEOUT: assert property (@(posedge clock) disable iff (!rst_n)
    ce && timeout_hit && !stop_det |=> is_aborted && !time_freeze && addr_ptr == PTR_AFTER_STOP)
    else $error("Timeout did not end access");

  AST_NO_RESTART: assert property (@(posedge clock) disable iff (!rst_n)
    ce && is_active && start_det && !osc_tick |=> to_cnt == $past(to_cnt))
    else $error("Repeated start moved timeout");

  AST_TO_BOUND: assert property (@(posedge clock) disable iff (!rst_n)
    to_cnt < TO_W'(TIMEOUT_MAX_TICKS))
    else $error("Timeout count past one second");

  AST_ABORT_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    is_aborted |-> !ack_enable && tx_byte == READ_ABORT)
    else $error("Aborted access still answers");

  AST_STOP_PTR: assert property (@(posedge clock) disable iff (!rst_n)
    ce && stop_det |=> addr_ptr == PTR_AFTER_STOP)
    else $error("Pointer not Fh after stop");

  AST_PTR_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    ce && byte_done && !ptr_load && !stop_det && !timeout_hit && !is_aborted
    |=> addr_ptr == $past(addr_ptr) + PTR_ONE)
    else $error("Pointer did not step");

  AST_CLK_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    ce |=> fixed_freq_clock_out == $past(osc_level))
    else $error("Clock output not following oscillator");

  COV_DEFERRED: cover property (@(posedge clock) disable iff (!rst_n)
    carry_pend ##1 carry_apply);

  COV_TIMEOUT: cover property (@(posedge clock) disable iff (!rst_n)
    is_active ##1 is_aborted);

  COV_RESTART: cover property (@(posedge clock) disable iff (!rst_n)
    is_active && start_det);

  COV_WRAP: cover property (@(posedge clock) disable iff (!rst_n)
    addr_ptr == PTR_AFTER_STOP && byte_done && is_active);
endmodule : rah_top

// *** test/rah_host_model.sv ***
// Purpose: Host bus master at event level
// Assumes: At most one event pulse per cycle
// Notes: Stall holds the stop back past the timeout
module rah_host_model #(
  parameter int GAP = 1525
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stall,
  output logic start_det,
  output logic stop_det,
  output logic ptr_load,
  output logic byte_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  bit act = 0;
  initial {start_det, stop_det, ptr_load, byte_done} = 4'h0;
  always @(posedge clock) begin
    {start_det, stop_det, ptr_load, byte_done} <= 4'h0;
    n <= n + 1;
    if (!rst_n) begin
      n <= 0;
      act <= 1'b0;
    end else if (!act && n >= GAP) begin
      start_det <= 1'b1;
      act <= 1'b1;
      n <= 0;
    end else if (act && n > (stall ? 400 : 20)) begin
      stop_det <= 1'b1;
      act <= 1'b0;
      n <= 0;
    end else if (act) begin
      {start_det, ptr_load, byte_done} <= 3'(1 << ($urandom % 8));
    end
  end
endmodule : rah_host_model

// *** test/rah_top_bench.sv ***
// Purpose: Random run against a cycle model
// Assumes: Small timeout count
// Notes: Stall phase forces timeouts
module rah_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int T = 4;
  logic clock, rst_n, ce, osc_level, stall, carry_due;
  logic start_det, stop_det, ptr_load, byte_done;
  logic [3:0] ptr_load_val, addr_ptr;
  logic [7:0] reg_rd_data, tx_byte;
  logic time_freeze, carry_apply, ack_enable, fixed_freq_clock_out, access_aborted;
  int num_errors = 0, total_checks = 0, ptr, cnt;
  bit frz, pend, ab, cap, ffo, od, tk, to;
  logic [7:0] tx;
  rah_top #(.TIMEOUT_TICKS(T)) DUT (.clock(clock), .rst_n(rst_n), .ce(ce),
    .osc_level(osc_level), .start_det(start_det), .stop_det(stop_det), .ptr_load(ptr_load),
    .ptr_load_val(ptr_load_val), .byte_done(byte_done), .carry_due(carry_due),
    .reg_rd_data(reg_rd_data), .time_freeze(time_freeze), .carry_apply(carry_apply),
    .addr_ptr(addr_ptr), .ack_enable(ack_enable), .tx_byte(tx_byte),
    .fixed_freq_clock_out(fixed_freq_clock_out), .access_aborted(access_aborted));
  rah_host_model host (.clock(clock), .rst_n(rst_n), .stall(stall),
    .start_det(start_det), .stop_det(stop_det), .ptr_load(ptr_load), .byte_done(byte_done));
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      {frz, pend, ab, cap, ffo, od} = 6'h0;
      ptr = 15;
      tx = 8'h00;
    end else if (ce) begin
      cap = 0;
      ffo = osc_level;
      tk = osc_level && !od;
      od = osc_level;
      to = frz && tk && cnt == T - 1;
      if (frz && tk) cnt++;
      if (stop_det || to) begin
        cap = pend || carry_due;
        {pend, frz} = 2'b00;
        ptr = 15;
        ab = !stop_det;
      end else begin
        if (start_det && !frz && !ab) begin
          frz = 1;
          cnt = 0;
        end
        if (frz) pend |= carry_due;
        else cap = carry_due;
        if (!ab && ptr_load) ptr = ptr_load_val;
        else if (!ab && byte_done) ptr = (ptr + 1) % 16;
      end
      tx = ab ? 8'hff : reg_rd_data;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  always @(negedge clock) if (rst_n) begin
    chk("time_freeze", 8'(frz), 8'(time_freeze));
    chk("carry_apply", 8'(cap), 8'(carry_apply));
    chk("access_aborted", 8'(ab), 8'(access_aborted));
    chk("addr_ptr", 8'(ptr), 8'(addr_ptr));
    chk("ack_enable", 8'(!ab), 8'(ack_enable));
    chk("tx_byte", tx, tx_byte);
    chk("clock_out", 8'(ffo), 8'(fixed_freq_clock_out));
  end
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    void'($urandom(32'ha946));
    {rst_n, ce, osc_level, stall, carry_due} = 5'h0;
    ptr_load_val = 4'h0;
    reg_rd_data = 8'h00;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 40000; i++) begin
      @(posedge clock);
      rst_n <= !(i >= 12000 && i < 12004);
      ce <= ($urandom % 8) != 0;
      if ($urandom % 16 == 0) osc_level <= ~osc_level;
      carry_due <= $urandom % 4 == 0;
      ptr_load_val <= 4'($urandom);
      reg_rd_data <= 8'($urandom);
      stall <= i > 20000;
    end
    results();
  end
endmodule : rah_top_bench
